/* hw/chp_dev_port.sv */
// device end of the channel host port with downstream and upstream relay
// How it works
// - channel lines are clock-aligned pulses, 25 ns rounded up to two cycles (40 ns)
// - processor pulses engaged to open or resume
// - engaged pulse accompanies every command flag
// - word under command flag is a function code
// - global clear after deadstart clears device state
// - twelve data lines carry words both ways
// - optional parity line gives odd parity
// - sender pulses word_offered when data valid
// - receiver pulses word_taken after capturing word
// - device answers each function with disconnect
// - either side may disconnect at any time while it is engaged (device) or linked (processor)
// - all channel lines relayed downstream, two-way lines upstream too
// - downstream copies lag processor lines 100 ns
// - upstream copies lag chained devices 100 ns
// - dual access uses two independent port instances
`timescale 1ns/100ps
`include "chp_consts.svh"
module chp_dev_port
	import chp_pkg::*;
#(
	parameter bit PARITY_EN = 1'b1,
	parameter int RC = `CHP_RELAY_CYC
) (
	// clock and reset
	input logic mclk,
	input logic srst,
	// host channel
	chp_chan_if.dev_end chan,
	// words from the processor
	output chp_word_t rx_word,
	output logic rx_func,
	output logic rx_valid,
	output logic rx_perr,
	// words to the processor
	input logic tx_valid,
	input chp_word_t tx_word,
	output logic tx_ready,
	// exchange control
	input logic disc_req,
	output logic engaged,
	output logic disc_seen,
	output logic cleared,
	// relay toward chained devices
	output chp_chan_s dn_relay,
	input chp_ret_s up_ret
);
	localparam logic [2:0] PC = 3'(`CHP_PULSE_CYC);

	// ==========================================
	// relay chains; the first two stages double as synchronisers,
	// so the logic sees the lines two cycles late and the relay
	// taps the end of the same chain
	chp_chan_s hs_reg [RC];
	chp_chan_s hs_next [RC];
	chp_ret_s us_reg [RC-1];
	chp_ret_s us_next [RC-1];
	always_comb begin
		hs_next[0] = {chan.clk1, chan.clk10, chan.eng, chan.cmd, chan.clr,
			chan.off, chan.tkn, chan.disc, chan.par, chan.data};
		us_next[0] = up_ret;
		for (int i = 1; i < RC; i++)
			hs_next[i] = hs_reg[i-1];
		for (int i = 1; i < RC - 1; i++)
			us_next[i] = us_reg[i-1];
	end
	always_ff @(posedge mclk) begin
		hs_reg <= hs_next;
		us_reg <= us_next;
	end
	assign dn_relay = hs_reg[RC-1]; // RC edges after the pin

	// ==========================================
	// edges of the synchronised processor lines
	chp_chan_s hc;
	logic slot, e_eng, e_cmd, e_clr, e_off, e_tkn, e_disc, perr;
	always_comb begin
		hc = hs_reg[1];
		slot = chp_rise(hc.clk10, hs_reg[2].clk10);
		e_eng = chp_rise(hc.eng, hs_reg[2].eng);
		e_cmd = chp_rise(hc.cmd, hs_reg[2].cmd);
		e_clr = chp_rise(hc.clr, hs_reg[2].clr);
		e_off = chp_rise(hc.off, hs_reg[2].off);
		e_tkn = chp_rise(hc.tkn, hs_reg[2].tkn);
		e_disc = chp_rise(hc.disc, hs_reg[2].disc);
		perr = PARITY_EN && (hc.par != chp_odd_par(hc.data));
	end

	// ==========================================
	// exchange sequencing
	chp_state_e st_reg, st_next;
	logic [2:0] pend_reg, pend_next, pul_reg, pul_next; // off, tkn, disc
	logic [2:0] pc_reg, pc_next;
	logic eng_reg, eng_next, drv_reg, drv_next, rdy_reg, rdy_next;
	chp_word_t wd_reg, wd_next, rx_reg, rx_next;
	logic fn_reg, fn_next, rv_reg, rv_next, pe_reg, pe_next;
	logic ds_reg, ds_next, cl_reg, cl_next;
	always_comb begin
		st_next = st_reg;
		pend_next = pend_reg;
		pul_next = pul_reg;
		pc_next = pc_reg;
		eng_next = eng_reg;
		drv_next = drv_reg;
		wd_next = wd_reg;
		rx_next = rx_reg;
		fn_next = fn_reg;
		pe_next = pe_reg;
		rv_next = 1'b0;
		ds_next = 1'b0;
		cl_next = 1'b0;
		// own pulses start on a clk10 rise and last the pulse width
		if (pc_reg != 3'h0) begin
			pc_next = pc_reg - 3'h1;
			if (pc_reg == 3'h1)
				pul_next = '0;
		end else if (slot && (pend_reg != '0)) begin
			pul_next = pend_reg;
			pend_next = '0;
			pc_next = PC;
		end
		// requests pending before the fire are set after it, so a
		// request raised in the firing cycle is kept for the next slot
		if (e_eng)
			eng_next = 1'b1;
		if (e_cmd) begin
			rx_next = hc.data;
			fn_next = 1'b1;
			pe_next = perr;
			rv_next = 1'b1;
			eng_next = 1'b1;
			pend_next[0] = 1'b1;
		end else if (e_off && st_reg != CHP_WAIT_TKN) begin
			// own offers echo on the wire; ignored while sending
			rx_next = hc.data;
			fn_next = 1'b0;
			pe_next = perr;
			rv_next = 1'b1;
			pend_next[1] = 1'b1;
		end
		case (st_reg)
			CHP_IDLE: begin
				if (rdy_reg && tx_valid) begin
					wd_next = tx_word;
					drv_next = 1'b1;
					pend_next[2] = 1'b1;
					st_next = CHP_WAIT_TKN;
				end
			end
			CHP_WAIT_TKN: begin
				if (e_tkn) begin
					drv_next = 1'b0;
					st_next = CHP_IDLE;
				end
			end
			default: begin
				st_next = CHP_IDLE;
			end
		endcase
		if (disc_req && eng_reg)
			pend_next[0] = 1'b1;
		if (e_disc) begin
			eng_next = 1'b0;
			drv_next = 1'b0;
			pend_next[2] = 1'b0;
			ds_next = 1'b1;
			st_next = CHP_IDLE;
		end
		if (e_clr) begin
			st_next = CHP_IDLE;
			pend_next = '0;
			pul_next = '0;
			pc_next = '0;
			eng_next = 1'b0;
			drv_next = 1'b0;
			fn_next = 1'b0;
			pe_next = 1'b0;
			rv_next = 1'b0;
			cl_next = 1'b1;
		end
		rdy_next = (st_next == CHP_IDLE) && eng_next && !tx_valid;
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= CHP_IDLE;
			pend_reg <= '0;
			pul_reg <= '0;
			pc_reg <= '0;
			eng_reg <= 1'b0;
			drv_reg <= 1'b0;
			rdy_reg <= 1'b0;
			wd_reg <= '0;
			rx_reg <= '0;
			fn_reg <= 1'b0;
			rv_reg <= 1'b0;
			pe_reg <= 1'b0;
			ds_reg <= 1'b0;
			cl_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			pend_reg <= pend_next;
			pul_reg <= pul_next;
			pc_reg <= pc_next;
			eng_reg <= eng_next;
			drv_reg <= drv_next;
			rdy_reg <= rdy_next;
			wd_reg <= wd_next;
			rx_reg <= rx_next;
			fn_reg <= fn_next;
			rv_reg <= rv_next;
			pe_reg <= pe_next;
			ds_reg <= ds_next;
			cl_reg <= cl_next;
		end
	end

	// ==========================================
	// channel drive: own traffic merged with the upstream copy;
	// own data wins if both drive, a clash the chain must avoid
	chp_ret_s o_reg, o_next, rt;
	always_comb begin
		rt = us_reg[RC-2]; // output flop adds the last stage
		o_next.off = pul_reg[2] | rt.off;
		o_next.tkn = pul_reg[1] | rt.tkn;
		o_next.disc = pul_reg[0] | rt.disc;
		o_next.drv = drv_reg | rt.drv;
		o_next.data = drv_reg ? wd_reg : rt.data;
		o_next.par = drv_reg ? (PARITY_EN & chp_odd_par(wd_reg)) : rt.par;
	end
	always_ff @(posedge mclk) begin
		if (srst)
			o_reg <= '0;
		else
			o_reg <= o_next;
	end
	assign chan.d_off_o = o_reg.off;
	assign chan.d_off_oe = o_reg.off;
	assign chan.d_tkn_o = o_reg.tkn;
	assign chan.d_tkn_oe = o_reg.tkn;
	assign chan.d_disc_o = o_reg.disc;
	assign chan.d_disc_oe = o_reg.disc;
	assign chan.d_data_o = o_reg.data;
	assign chan.d_data_oe = o_reg.drv;
	assign chan.d_par_o = o_reg.par;
	assign chan.d_par_oe = o_reg.drv;

	// ==========================================
	// user side, all from flops; a dual-access unit instantiates
	// this module once per processor
	assign rx_word = rx_reg;
	assign rx_func = fn_reg;
	assign rx_valid = rv_reg;
	assign rx_perr = pe_reg;
	assign tx_ready = rdy_reg;
	assign engaged = eng_reg;
	assign disc_seen = ds_reg;
	assign cleared = cl_reg;
endmodule

/* shared/chp_consts.svh */
// timing and width constants for the channel host port
`ifndef CHP_CONSTS_SVH
`define CHP_CONSTS_SVH
`define CHP_WORD_W 12
`define CHP_CLK_NS 20
`define CHP_PULSE_NS 25
`define CHP_PULSE_CYC ((`CHP_PULSE_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_RELAY_NS 100
`define CHP_RELAY_CYC (`CHP_RELAY_NS / `CHP_CLK_NS)
`define CHP_C10_NS 100
`define CHP_C10_CYC (`CHP_C10_NS / `CHP_CLK_NS)
`define CHP_C1_NS 1000
`define CHP_C1_CYC (`CHP_C1_NS / `CHP_CLK_NS)
`endif

/* shared/chp_pkg.sv */
// types and helpers shared by both ends of the channel host port
`include "chp_consts.svh"
package chp_pkg;
	typedef logic [`CHP_WORD_W-1:0] chp_word_t;
	// lines as seen from the peripheral processor side
	typedef struct packed {
		logic clk1;
		logic clk10;
		logic eng;
		logic cmd;
		logic clr;
		logic off;
		logic tkn;
		logic disc;
		logic par;
		chp_word_t data;
	} chp_chan_s;
	// lines that travel back toward the peripheral processor
	typedef struct packed {
		logic drv;
		logic off;
		logic tkn;
		logic disc;
		logic par;
		chp_word_t data;
	} chp_ret_s;
	typedef enum logic [1:0] {CHP_IDLE, CHP_WAIT_TKN, CHP_WAIT_DISC} chp_state_e;
	function automatic logic chp_odd_par(input chp_word_t w);
		return ~^w;
	endfunction
	function automatic logic chp_rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction
endpackage

/* shared/chp_chan_if.sv */
// host channel between the peripheral processor end and the device end
`timescale 1ns/100ps
interface chp_chan_if;
	import chp_pkg::*;
	// driven by the peripheral processor only
	logic clk1;
	logic clk10;
	logic eng;
	logic cmd;
	logic clr;
	// two-way lines, one output and enable per end
	logic h_off_o, h_off_oe, d_off_o, d_off_oe;
	logic h_tkn_o, h_tkn_oe, d_tkn_o, d_tkn_oe;
	logic h_disc_o, h_disc_oe, d_disc_o, d_disc_oe;
	logic h_par_o, h_par_oe, d_par_o, d_par_oe;
	chp_word_t h_data_o, d_data_o;
	logic h_data_oe, d_data_oe;
	// resolved wire levels; pulse lines are wired-or
	logic off, tkn, disc, par;
	chp_word_t data;
	assign off = (h_off_o & h_off_oe) | (d_off_o & d_off_oe);
	assign tkn = (h_tkn_o & h_tkn_oe) | (d_tkn_o & d_tkn_oe);
	assign disc = (h_disc_o & h_disc_oe) | (d_disc_o & d_disc_oe);
	assign par = d_par_oe ? d_par_o : (h_par_oe & h_par_o);
	assign data = d_data_oe ? d_data_o : (h_data_oe ? h_data_o : '0);
	modport host_end (
		output clk1, clk10, eng, cmd, clr,
		output h_off_o, h_off_oe, h_tkn_o, h_tkn_oe, h_disc_o, h_disc_oe,
		output h_par_o, h_par_oe, h_data_o, h_data_oe,
		input off, tkn, disc, par, data
	);
	modport dev_end (
		input clk1, clk10, eng, cmd, clr,
		output d_off_o, d_off_oe, d_tkn_o, d_tkn_oe, d_disc_o, d_disc_oe,
		output d_par_o, d_par_oe, d_data_o, d_data_oe,
		input off, tkn, disc, par, data
	);
endinterface

/* hw/chp_host_port.sv */
// peripheral processor end of the channel host port
`timescale 1ns/100ps
`include "chp_consts.svh"
module chp_host_port
	import chp_pkg::*;
#(
	parameter bit PARITY_EN = 1'b1,
	parameter int C10_CYC = `CHP_C10_CYC,
	parameter int C1_CYC = `CHP_C1_CYC
) (
	// clock and reset
	input logic mclk,
	input logic srst,
	// host channel
	chp_chan_if.host_end chan,
	// requests
	input logic func_valid,
	input chp_word_t func_code,
	input logic tx_valid,
	input chp_word_t tx_word,
	input logic open_req,
	input logic disc_req,
	output logic ready,
	// answers
	output chp_word_t rx_word,
	output logic rx_valid,
	output logic rx_perr,
	output logic disc_seen,
	output logic linked
);
	localparam logic [2:0] PC = 3'(`CHP_PULSE_CYC);
	localparam int W10 = $clog2(C10_CYC);
	localparam int W1 = $clog2(C1_CYC);

	// ==========================================
	// clock dividers
	logic [W10-1:0] c10_reg, c10_next;
	logic [W1-1:0] c1_reg, c1_next;
	logic clk10_reg, clk10_next, clk1_reg, clk1_next, slot;
	always_comb begin
		slot = (c10_reg == W10'(C10_CYC - 1)); // next edge raises clk10
		c10_next = slot ? '0 : c10_reg + 1'b1;
		c1_next = (c1_reg == W1'(C1_CYC - 1)) ? '0 : c1_reg + 1'b1;
		clk10_next = (c10_next < W10'(C10_CYC / 2));
		clk1_next = (c1_next < W1'(C1_CYC / 2));
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			// start at the wrap so the first clk10 rise is a full one and carries the clear
			c10_reg <= W10'(C10_CYC - 1);
			c1_reg <= W1'(C1_CYC - 1);
			clk10_reg <= 1'b0;
			clk1_reg <= 1'b0;
		end else begin
			c10_reg <= c10_next;
			c1_reg <= c1_next;
			clk10_reg <= clk10_next;
			clk1_reg <= clk1_next;
		end
	end

	// ==========================================
	// channel input synchronisers, [0] feeds only [1]
	chp_ret_s s_reg [3];
	chp_ret_s s_next [3];
	chp_ret_s sc;
	logic e_off, e_tkn, e_disc;
	always_comb begin
		s_next[0] = {1'b0, chan.off, chan.tkn, chan.disc, chan.par, chan.data};
		s_next[1] = s_reg[0];
		s_next[2] = s_reg[1];
		sc = s_reg[1];
		e_off = chp_rise(sc.off, s_reg[2].off);
		e_tkn = chp_rise(sc.tkn, s_reg[2].tkn);
		e_disc = chp_rise(sc.disc, s_reg[2].disc);
	end
	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	// ==========================================
	// exchange sequencing
	chp_state_e st_reg, st_next;
	logic [5:0] pend_reg, pend_next, pul_reg, pul_next; // clr,eng,cmd,off,tkn,disc
	logic [2:0] pc_reg, pc_next;
	logic lk_reg, lk_next, drv_reg, drv_next, rdy_reg, rdy_next;
	chp_word_t wd_reg, wd_next, rx_reg, rx_next;
	logic rv_reg, rv_next, pe_reg, pe_next, ds_reg, ds_next;
	logic pa_reg, pa_next;
	always_comb begin
		st_next = st_reg;
		pend_next = pend_reg;
		pul_next = pul_reg;
		pc_next = pc_reg;
		lk_next = lk_reg;
		drv_next = drv_reg;
		wd_next = wd_reg;
		rx_next = rx_reg;
		pe_next = pe_reg;
		rv_next = 1'b0;
		ds_next = 1'b0;
		// pulses leave together with the clk10 rise
		if (pc_reg != 3'h0) begin
			pc_next = pc_reg - 3'h1;
			if (pc_reg == 3'h1)
				pul_next = '0;
		end else if (slot && (pend_reg != '0)) begin
			pul_next = pend_reg;
			pend_next = '0;
			pc_next = PC;
		end
		if (rdy_reg && func_valid) begin
			wd_next = func_code;
			drv_next = 1'b1;
			pend_next[4] = 1'b1;
			pend_next[3] = 1'b1;
			lk_next = 1'b1;
			st_next = CHP_WAIT_DISC;
		end else if (rdy_reg && tx_valid) begin
			wd_next = tx_word;
			drv_next = 1'b1;
			pend_next[2] = 1'b1;
			pend_next[4] = pend_next[4] | ~lk_reg;
			lk_next = 1'b1;
			st_next = CHP_WAIT_TKN;
		end else if (rdy_reg && open_req && !lk_reg) begin
			pend_next[4] = 1'b1;
			lk_next = 1'b1;
		end
		if (st_reg == CHP_WAIT_TKN && e_tkn) begin
			drv_next = 1'b0;
			st_next = CHP_IDLE;
		end
		if (e_off && st_reg == CHP_IDLE && !drv_reg) begin
			rx_next = sc.data;
			pe_next = PARITY_EN && (sc.par != chp_odd_par(sc.data));
			rv_next = 1'b1;
			pend_next[1] = 1'b1;
		end
		if (disc_req && lk_reg)
			pend_next[0] = 1'b1;
		if (e_disc) begin
			lk_next = 1'b0;
			drv_next = 1'b0;
			ds_next = 1'b1;
			st_next = CHP_IDLE;
		end
		rdy_next = (st_next == CHP_IDLE) && !pend_next[5] && !func_valid && !tx_valid;
		pa_next = PARITY_EN & chp_odd_par(wd_next);
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= CHP_IDLE;
			pend_reg <= 6'h20; // clear follows deadstart
			pul_reg <= '0;
			pc_reg <= '0;
			lk_reg <= 1'b0;
			drv_reg <= 1'b0;
			rdy_reg <= 1'b0;
			wd_reg <= '0;
			rx_reg <= '0;
			rv_reg <= 1'b0;
			pe_reg <= 1'b0;
			ds_reg <= 1'b0;
			pa_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			pend_reg <= pend_next;
			pul_reg <= pul_next;
			pc_reg <= pc_next;
			lk_reg <= lk_next;
			drv_reg <= drv_next;
			rdy_reg <= rdy_next;
			wd_reg <= wd_next;
			rx_reg <= rx_next;
			rv_reg <= rv_next;
			pe_reg <= pe_next;
			ds_reg <= ds_next;
			pa_reg <= pa_next;
		end
	end

	// ==========================================
	// outputs, all from flops
	assign chan.clk1 = clk1_reg;
	assign chan.clk10 = clk10_reg;
	assign chan.clr = pul_reg[5];
	assign chan.eng = pul_reg[4];
	assign chan.cmd = pul_reg[3];
	assign chan.h_off_o = pul_reg[2];
	assign chan.h_off_oe = pul_reg[2];
	assign chan.h_tkn_o = pul_reg[1];
	assign chan.h_tkn_oe = pul_reg[1];
	assign chan.h_disc_o = pul_reg[0];
	assign chan.h_disc_oe = pul_reg[0];
	assign chan.h_data_o = wd_reg;
	assign chan.h_data_oe = drv_reg;
	assign chan.h_par_o = pa_reg;
	assign chan.h_par_oe = drv_reg;
	assign ready = rdy_reg;
	assign rx_word = rx_reg;
	assign rx_valid = rv_reg;
	assign rx_perr = pe_reg;
	assign disc_seen = ds_reg;
	assign linked = lk_reg;
endmodule

/* tb/chp_sva.sv */
// concurrent checks on the wires of the host channel
`timescale 1ns/100ps
module chp_sva
	import chp_pkg::*;
(
	// clock and reset
	input logic mclk,
	input logic srst,
	// wires driven by the processor end
	input logic clk10,
	input logic eng,
	input logic cmd,
	input logic clr,
	// shared wires
	input logic off,
	input logic tkn,
	input logic disc,
	input logic par,
	input chp_word_t data,
	input logic h_data_oe,
	input logic d_data_oe
);
	// ==========
	// one domain, so clock and disable are given once
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	// ==========
	// clocks and pulse shapes
	clk10_period_a: assert property (
		$rose(clk10) |=> (!$rose(clk10)) [*4] ##1 $rose(clk10)) else $error("clk10 period is not five cycles");
	eng_width_a: assert property (
		$rose(eng) |=> eng ##1 !eng) else $error("engaged pulse width wrong");
	offer_width_a: assert property (
		$rose(off) |=> off ##1 !off) else $error("offered pulse width wrong");
	clear_after_reset_a: assert property (
		$fell(srst) |-> ##[1:15] $rose(clr)) else $error("no global clear after restart");

	// ==========
	// exchange order
	cmd_with_eng_a: assert property (
		cmd |-> eng) else $error("command flag without engaged");
	func_disc_a: assert property (
		$rose(cmd) |-> ##[1:20] $rose(disc)) else $error("function not answered by disconnect");
	offer_taken_a: assert property (
		$rose(off) |=> ##[0:20] $rose(tkn)) else $error("offered word never taken");
	one_offer_a: assert property (
		$rose(off) |=> (!$rose(off)) until $rose(tkn)) else $error("second offer before taken");

	// ==========
	// data lines
	offer_par_a: assert property (
		off |-> par == ~^data) else $error("parity not odd during offer");
	offer_hold_a: assert property (
		$rose(off) |=> $stable(data)) else $error("data moved during offer");
	one_driver_a: assert property (
		!(h_data_oe && d_data_oe)) else $error("both ends drive the data lines");
endmodule

/* tb/channel_host_port_tb.sv */
// self-checking bench joining both ends of the channel host port
`timescale 1ns/100ps
module channel_host_port_tb;
	import chp_pkg::*;
	// ==========
	// stimulus and observed signals
	logic mclk, h_srst, d_srst, h_func_valid, h_tx_valid, h_open, h_disc, d_tx_valid, d_disc, mon_en;
	logic ready, h_rx_valid, h_rx_perr, h_disc_seen, linked;
	logic d_rx_func, d_rx_valid, d_rx_perr, tx_ready, engaged, d_disc_seen, cleared;
	chp_word_t h_func_code, h_tx_word, d_tx_word, h_rx_word, d_rx_word, w;
	chp_chan_s dn_relay, wire_now;
	chp_ret_s up_ret;
	chp_chan_s hist[$];
	int errors, num_checks, op;

	chp_chan_if chp_chan_if_i();
	chp_host_port chp_host_port_i(.mclk(mclk), .srst(h_srst), .chan(chp_chan_if_i), .func_valid(h_func_valid),
		.func_code(h_func_code), .tx_valid(h_tx_valid), .tx_word(h_tx_word), .open_req(h_open), .disc_req(h_disc),
		.ready(ready), .rx_word(h_rx_word), .rx_valid(h_rx_valid), .rx_perr(h_rx_perr), .disc_seen(h_disc_seen),
		.linked(linked));
	chp_dev_port chp_dev_port_i(.mclk(mclk), .srst(d_srst), .chan(chp_chan_if_i), .rx_word(d_rx_word),
		.rx_func(d_rx_func), .rx_valid(d_rx_valid), .rx_perr(d_rx_perr), .tx_valid(d_tx_valid), .tx_word(d_tx_word),
		.tx_ready(tx_ready), .disc_req(d_disc), .engaged(engaged), .disc_seen(d_disc_seen), .cleared(cleared),
		.dn_relay(dn_relay), .up_ret(up_ret));
	// checker follows the end that drives the clocks
	chp_sva chp_sva_i(.mclk(mclk), .srst(h_srst), .clk10(chp_chan_if_i.clk10), .eng(chp_chan_if_i.eng),
		.cmd(chp_chan_if_i.cmd), .clr(chp_chan_if_i.clr), .off(chp_chan_if_i.off), .tkn(chp_chan_if_i.tkn),
		.disc(chp_chan_if_i.disc), .par(chp_chan_if_i.par), .data(chp_chan_if_i.data),
		.h_data_oe(chp_chan_if_i.h_data_oe), .d_data_oe(chp_chan_if_i.d_data_oe));

	assign wire_now = {chp_chan_if_i.clk1, chp_chan_if_i.clk10, chp_chan_if_i.eng, chp_chan_if_i.cmd,
		chp_chan_if_i.clr, chp_chan_if_i.off, chp_chan_if_i.tkn, chp_chan_if_i.disc, chp_chan_if_i.par,
		chp_chan_if_i.data};

	// ==========
	// clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ==========
	// expectations and compares
	function automatic logic exp_par(input chp_word_t d);
		return ^d ^ 1'b1;
	endfunction
	task automatic chk_word(input chp_word_t got, input chp_word_t exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rel(input chp_chan_s got, input chp_chan_s exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected relay at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========
	// relay lag and wire parity, sampled mid-cycle; relay flops hold stale values after reset
	always @(negedge mclk) begin
		if (!mon_en) begin
			hist.delete();
		end else begin
			if (hist.size() == 5) begin
				chk_rel(dn_relay, hist.pop_front());
			end
			if (wire_now.off === 1'b1) begin
				chk_bit(wire_now.par, exp_par(wire_now.data));
			end
			hist.push_back(wire_now);
		end
	end

	// ==========
	// bounded waits, polled at the falling edge
	task automatic wait_for(input int which);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < 200) begin
			@(negedge mclk);
			n++;
			case (which)
				0: hit = (ready === 1'b1);
				1: hit = (d_rx_valid === 1'b1);
				2: hit = (h_rx_valid === 1'b1);
				3: hit = (tx_ready === 1'b1);
				4: hit = (h_disc_seen === 1'b1);
				5: hit = (cleared === 1'b1);
				6: hit = (linked === 1'b0);
				7: hit = (engaged === 1'b0);
				default: hit = (engaged === 1'b1);
			endcase
		end
		if (!hit) begin
			errors++;
			$display("unexpected timeout at %0t: wait %h expected %h", $time, which, 1);
			report_and_stop();
		end
	endtask
	// one-cycle request, launched at a falling edge
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask

	// ==========
	// main sequence
	initial begin
		{h_func_valid, h_tx_valid, h_open, h_disc, d_tx_valid, d_disc, mon_en} = '0;
		{h_srst, d_srst} = 2'b11;
		{h_func_code, h_tx_word, d_tx_word, w} = '0;
		up_ret = '0;
		errors = 0;
		num_checks = 0;
		void'($urandom(67));
		repeat (10) @(negedge mclk);
		{h_srst, d_srst} = 2'b00;
		wait_for(5);
		repeat (10) @(negedge mclk);
		mon_en = 1'b1;
		for (int i = 0; i < 14; i++) begin
			op = (i < 4) ? i : int'($urandom % 4);
			w = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
			wait_for(0);
			case (op)
				0: begin // function code, answered by disconnect
					h_func_code = w;
					pulse(h_func_valid);
					wait_for(1);
					chk_word(d_rx_word, w);
					chk_bit(d_rx_func, 1'b1);
					chk_bit(d_rx_perr, 1'b0);
					wait_for(4);
					chk_bit(d_disc_seen, 1'b1);
				end
				1: begin // host writes, then host ends the exchange
					h_tx_word = w;
					pulse(h_tx_valid);
					wait_for(1);
					chk_word(d_rx_word, w);
					chk_bit(d_rx_func, 1'b0);
					chk_bit(d_rx_perr, 1'b0);
					wait_for(0);
					pulse(h_disc);
					wait_for(7);
				end
				2: begin // host opens a read, device answers and ends it
					pulse(h_open);
					wait_for(3);
					d_tx_word = w;
					pulse(d_tx_valid);
					wait_for(2);
					chk_word(h_rx_word, w);
					chk_bit(h_rx_perr, 1'b0);
					wait_for(3);
					pulse(d_disc);
					wait_for(6);
				end
				default: begin // chained device pulse returned upstream
					up_ret.tkn = 1'b1;
					repeat (2) @(negedge mclk);
					up_ret.tkn = 1'b0;
					repeat (2) @(negedge mclk);
					chk_bit(chp_chan_if_i.tkn, 1'b0);
					@(negedge mclk);
					chk_bit(chp_chan_if_i.tkn, 1'b1);
					// a stray taken pulse would release a following host write
					repeat (4) @(negedge mclk);
				end
			endcase
			$display("test %0d op %0d done", i, op);
		end
		// host restarts mid-exchange; its global clear must drop the device
		wait_for(0);
		pulse(h_open);
		wait_for(8);
		mon_en = 1'b0;
		h_srst = 1'b1;
		repeat (10) @(negedge mclk);
		h_srst = 1'b0;
		wait_for(5);
		chk_bit(engaged, 1'b0);
		$display("test restart done");
		report_and_stop();
	end
endmodule
